// file: logic/ast_pkg.sv
// constants, field positions and types for the async serial transmitter block
// assumes 8-bit registers behind a 32-bit avalon-mm slave, one word per register
package ast_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] AST_IDX_PSC = 6'h09;
    localparam logic [5:0] AST_IDX_ARB_CTL = 6'h0A;
    localparam logic [5:0] AST_IDX_ARB_RES = 6'h0B;
    localparam logic [5:0] AST_IDX_CTL1 = 6'h13;
    localparam logic [5:0] AST_IDX_CTL2 = 6'h14;
    localparam logic [5:0] AST_IDX_CTL3 = 6'h15;
    localparam logic [5:0] AST_IDX_STA1 = 6'h16;
    localparam logic [5:0] AST_IDX_STA2 = 6'h17;
    localparam logic [5:0] AST_IDX_DATA = 6'h18;
    localparam logic [5:0] AST_IDX_BAUD = 6'h19;
    // reset values
    localparam logic [7:0] AST_RST_CTL = 8'h00;
    localparam logic [7:0] AST_RST_STA1 = 8'hC0;
    // serial_control_one fields
    localparam int AST_B_IFACE_ON = 6;
    localparam int AST_B_POL_FLIP = 5;
    localparam int AST_B_WLEN = 4;
    // serial_control_two fields
    localparam int AST_B_TXE_IRQ = 7;
    localparam int AST_B_TXD_IRQ = 6;
    localparam int AST_B_TX_ON = 3;
    localparam int AST_B_RX_ON = 2;
    localparam int AST_B_BREAK = 0;
    // serial_control_three fields and writable mask
    localparam int AST_B_RX8 = 7;
    localparam int AST_B_TX8 = 6;
    localparam logic [7:0] AST_CTL3_WMASK = 8'h4F;
    // serial_status_one fields
    localparam int AST_B_TXE = 7;
    localparam int AST_B_TXD = 6;
    localparam int AST_B_RXF = 5;
    localparam int AST_B_OVR = 3;
    localparam int AST_B_FERR = 1;
    // serial_status_two fields
    localparam int AST_B_BRK = 1;
    localparam int AST_B_RXP = 0;
    // baud_rate_select fields; bit 3 reserved, reads zero
    localparam int AST_B_LONG_BRK = 6;
    localparam logic [7:0] AST_BAUD_WMASK = 8'hF7;
    // frame timing
    localparam logic [3:0] AST_FRM_LEN8 = 4'hA;
    localparam logic [3:0] AST_FRM_LEN9 = 4'hB;
    localparam logic [3:0] AST_RT_LAST = 4'hF;
    localparam logic [3:0] AST_RT_SAMPLE = 4'h7;
    localparam logic [3:0] AST_DATA_BITS8 = 4'h8;
    localparam logic [3:0] AST_DATA_BITS9 = 4'h9;
    // increment of the rate accumulator per bus clock
    localparam logic [11:0] AST_INC_BUS = 12'h001;
    localparam logic [11:0] AST_INC_GEN = 12'h004;
    // character kinds in the shifter
    typedef enum logic [2:0] {
        AST_TXK_NONE = 3'b000,
        AST_TXK_DATA = 3'b001,
        AST_TXK_IDLE = 3'b010,
        AST_TXK_BREAK = 3'b011,
        AST_TXK_TAIL = 3'b100
    } ast_tx_kind_t;
    // receiver states
    typedef enum logic {
        AST_RX_IDLE = 1'b0,
        AST_RX_RUN = 1'b1
    } ast_rx_state_t;
endpackage : ast_pkg

// file: logic/ast_baud_gen.sv
// oversampling tick generator, sixteen ticks per bit time
// assumes one bus clock; the generator clock is modelled as four counts per bus edge
`timescale 1ns/1ps
module ast_baud_gen (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // rate selection
    input wire logic run_in,
    input wire logic clk_src_choice_in,
    input wire logic [1:0] scp_in,
    input wire logic [2:0] scr_in,
    // tick out
    output logic rt_tick_out
);
    import ast_pkg::*;
    logic [11:0] acc_q, acc_d; // rate accumulator
    logic [11:0] limit; // counts per tick
    logic [11:0] inc; // counts per bus edge
    logic tick_q, tick_d; // registered tick

    // four-times clock counts four per bus edge, keeping one domain
    always_comb begin
        inc = clk_src_choice_in ? AST_INC_BUS : AST_INC_GEN;
        limit = 12'({2'b00, scp_in} + 4'h1) << (5'd2 + 5'(scr_in));
        acc_d = acc_q + inc;
        tick_d = 1'b0;
        if (!run_in) begin
            acc_d = 12'h000;
        end else if (acc_d >= limit) begin
            acc_d = acc_d - limit; // limit never below four, so one tick per edge suffices
            tick_d = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc_q <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign rt_tick_out = tick_q;
endmodule : ast_baud_gen

// file: logic/ast_serial_top.sv
// async serial transmitter with break recognition and register file
// assumes an avalon-mm master on the bus clock and an asynchronous receive pin
`timescale 1ns/1ps
module ast_serial_top (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // strap: one selects bus clock, zero the four-times clock
    input wire logic clk_src_choice_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // serial pins
    input wire logic rxd_in,
    output logic txd_out,
    output logic txd_oe_out,
    output logic rx_pin_claim_out,
    // transmitter interrupt request
    output logic tx_irq_out
);
    import ast_pkg::*;

    // bus handshake state
    logic ack_q, ack_d; // second cycle of an access
    logic [7:0] rdata_q, rdata_d; // captured read word
    logic req, acc_rd, acc_wr; // request and accepted strobes
    logic [5:0] idx; // register index
    logic [7:0] wdat; // low write byte
    logic [7:0] rd_mux; // read selection

    // software registers and flags
    logic [7:0] psc_q, psc_d; // prescaler, stored only
    logic [7:0] arb_q, arb_d; // arbiter control, stored only
    logic [7:0] ctl1_q, ctl1_d;
    logic [7:0] ctl2_q, ctl2_d;
    logic [7:0] ctl3_q, ctl3_d; // writable bits of control three
    logic [7:0] baud_q, baud_d;
    logic [7:0] txbuf_q, txbuf_d; // write side of the data register
    logic [7:0] rxbuf_q, rxbuf_d; // read side of the data register
    logic rx8_q, rx8_d;
    logic txe_q, txe_d; // tx_buffer_empty_flag
    logic rxf_q, rxf_d; // rx_full_flag
    logic ovr_q, ovr_d;
    logic fe_q, fe_d; // frame_err
    logic bkf_q, bkf_d; // break_flag
    logic arm_tx_q, arm_tx_d; // status read seen with empty flag set
    logic arm_rx_q, arm_rx_d; // status read seen with receive flags
    logic arm_bk_q, arm_bk_d; // status two read seen with break flag
    logic tc; // tx_done_flag, derived

    // decoded controls
    logic iface_on, tx_on, rx_on, pol_flip, wlen9, send_break_bit, long_brk;

    // transmitter state
    ast_tx_kind_t kind_q, kind_d;
    logic [12:0] sh_q, sh_d; // shift register, bit 0 on the line
    logic [3:0] left_q, left_d; // bits still to send
    logic [3:0] trt_q, trt_d; // oversample count within a bit
    logic idle_pend_q, idle_pend_d; // queued idle character
    logic tail_q, tail_d; // one guard bit owed after a break
    logic te_prev_q, te_prev_d;
    logic txd_q, txd_d, oe_q, oe_d;
    logic tx_take; // buffer handed to shifter
    logic tx_drop; // buffered data lost on late enable
    logic tx_end; // shifter free this cycle
    logic [3:0] frm_len;

    // receiver state
    ast_rx_state_t rst_q, rst_d;
    logic s1_q, s2_q, s3_q; // pin synchroniser
    logic rxl_q, rxl_d, rxp_q, rxp_d; // filtered level and previous
    logic [3:0] rrt_q, rrt_d, ridx_q, ridx_d;
    logic [8:0] rsh_q, rsh_d;
    logic allz_q, allz_d; // every sample so far was zero
    logic rx_done, rx_brk, rx_ferr; // end-of-frame pulses
    logic [3:0] ndata;
    logic rt_tick;

    assign iface_on = ctl1_q[AST_B_IFACE_ON];
    assign pol_flip = ctl1_q[AST_B_POL_FLIP];
    assign wlen9 = ctl1_q[AST_B_WLEN];
    assign tx_on = ctl2_q[AST_B_TX_ON];
    assign rx_on = ctl2_q[AST_B_RX_ON];
    assign send_break_bit = ctl2_q[AST_B_BREAK];
    assign long_brk = baud_q[AST_B_LONG_BRK];
    assign frm_len = wlen9 ? AST_FRM_LEN9 : AST_FRM_LEN8;
    assign ndata = wlen9 ? AST_DATA_BITS9 : AST_DATA_BITS8;

    // bus slave: one wait cycle for every access, answer on the second
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~ack_q;
    assign acc_rd = avs_read_in & ack_q;
    assign acc_wr = avs_write_in & ack_q & avs_byteenable_in[0];
    assign idx = avs_address_in[7:2];
    assign wdat = avs_writedata_in[7:0];
    assign avs_readdata_out = {24'h000000, rdata_q};

    // done when shifter, buffer and queued characters are all empty
    assign tc = (left_q == 4'h0) & txe_q & ~idle_pend_q & ~tail_q & ~(send_break_bit & tx_on);
    assign tx_irq_out = (txe_q & ctl2_q[AST_B_TXE_IRQ]) | (tc & ctl2_q[AST_B_TXD_IRQ]);

    // read mux; unmapped indices read zero
    always_comb begin
        case (idx)
            AST_IDX_PSC: rd_mux = psc_q;
            AST_IDX_ARB_CTL: rd_mux = arb_q;
            AST_IDX_ARB_RES: rd_mux = 8'h00;
            AST_IDX_CTL1: rd_mux = ctl1_q;
            AST_IDX_CTL2: rd_mux = ctl2_q;
            AST_IDX_CTL3: rd_mux = ctl3_q | {rx8_q, 7'h00};
            AST_IDX_STA1: rd_mux = {txe_q, tc, rxf_q, 1'b0, ovr_q, 1'b0, fe_q, 1'b0};
            AST_IDX_STA2: rd_mux = {6'h00, bkf_q, rst_q == AST_RX_RUN};
            AST_IDX_DATA: rd_mux = rxbuf_q;
            AST_IDX_BAUD: rd_mux = baud_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // register file and flags; hardware sets win over software clears
    always_comb begin
        ack_d = req & ~ack_q;
        rdata_d = (req & ~ack_q) ? rd_mux : rdata_q;
        psc_d = psc_q;
        arb_d = arb_q;
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        ctl3_d = ctl3_q;
        baud_d = baud_q;
        txbuf_d = txbuf_q;
        rxbuf_d = rxbuf_q;
        rx8_d = rx8_q;
        txe_d = txe_q;
        rxf_d = rxf_q;
        ovr_d = ovr_q;
        fe_d = fe_q;
        bkf_d = bkf_q;
        arm_tx_d = arm_tx_q;
        arm_rx_d = arm_rx_q;
        arm_bk_d = arm_bk_q;
        // writes
        if (acc_wr) begin
            case (idx)
                AST_IDX_PSC: psc_d = wdat;
                AST_IDX_ARB_CTL: arb_d = wdat;
                AST_IDX_CTL1: ctl1_d = wdat;
                AST_IDX_CTL2: ctl2_d = wdat;
                AST_IDX_CTL3: ctl3_d = wdat & AST_CTL3_WMASK;
                AST_IDX_BAUD: baud_d = wdat & AST_BAUD_WMASK;
                AST_IDX_DATA: begin
                    txbuf_d = wdat;
                    if (arm_tx_q) begin
                        txe_d = 1'b0; // read-then-write clears the empty flag
                        arm_tx_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // reads that arm or clear flags
        if (acc_rd && idx == AST_IDX_STA1) begin
            arm_tx_d = txe_q;
            arm_rx_d = rxf_q | ovr_q | fe_q;
        end
        if (acc_rd && idx == AST_IDX_STA2) begin
            arm_bk_d = bkf_q;
        end
        if (acc_rd && idx == AST_IDX_DATA) begin
            if (arm_rx_q) begin
                rxf_d = 1'b0;
                ovr_d = 1'b0;
                fe_d = 1'b0;
                arm_rx_d = 1'b0;
            end
            if (arm_bk_q) begin
                bkf_d = 1'b0;
                arm_bk_d = 1'b0;
            end
        end
        // hardware sets last so they win
        if (tx_take || tx_drop) begin
            txe_d = 1'b1;
        end
        if (rx_done) begin
            if (rxf_q && rxf_d) begin
                ovr_d = 1'b1; // unread character kept, new one lost
            end else begin
                rxbuf_d = rx_brk ? 8'h00 : (wlen9 ? rsh_q[7:0] : rsh_q[8:1]);
                rx8_d = rx_brk ? 1'b0 : rsh_q[8];
            end
            rxf_d = 1'b1;
            fe_d = fe_d | rx_ferr | rx_brk;
            bkf_d = bkf_d | rx_brk;
        end
    end

    // registers only; data register contents are reset to zero along with the other registers except txe_q, which resets to one
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
            psc_q <= AST_RST_CTL;
            arb_q <= AST_RST_CTL;
            ctl1_q <= AST_RST_CTL;
            ctl2_q <= AST_RST_CTL;
            ctl3_q <= AST_RST_CTL;
            baud_q <= AST_RST_CTL;
            txbuf_q <= 8'h00;
            rxbuf_q <= 8'h00;
            rx8_q <= 1'b0;
            txe_q <= AST_RST_STA1[AST_B_TXE];
            rxf_q <= 1'b0;
            ovr_q <= 1'b0;
            fe_q <= 1'b0;
            bkf_q <= 1'b0;
            arm_tx_q <= 1'b0;
            arm_rx_q <= 1'b0;
            arm_bk_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            psc_q <= psc_d;
            arb_q <= arb_d;
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
            ctl3_q <= ctl3_d;
            baud_q <= baud_d;
            txbuf_q <= txbuf_d;
            rxbuf_q <= rxbuf_d;
            rx8_q <= rx8_d;
            txe_q <= txe_d;
            rxf_q <= rxf_d;
            ovr_q <= ovr_d;
            fe_q <= fe_d;
            bkf_q <= bkf_d;
            arm_tx_q <= arm_tx_d;
            arm_rx_q <= arm_rx_d;
            arm_bk_q <= arm_bk_d;
        end
    end

    // oversampling tick, shared by both directions
    ast_baud_gen u_baud (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .run_in(iface_on),
        .clk_src_choice_in(clk_src_choice_in),
        .scp_in(baud_q[5:4]),
        .scr_in(baud_q[2:0]),
        .rt_tick_out(rt_tick)
    );

    // transmitter: shift, then pick the next character at a bit boundary
    always_comb begin
        kind_d = kind_q;
        sh_d = sh_q;
        left_d = left_q;
        trt_d = trt_q;
        idle_pend_d = idle_pend_q;
        tail_d = tail_q;
        te_prev_d = tx_on;
        tx_take = 1'b0;
        tx_drop = 1'b0;
        tx_end = (left_q == 4'h0);
        if (!iface_on) begin
            left_d = 4'h0; // released pins, nothing in flight
            kind_d = AST_TXK_NONE;
            trt_d = 4'h0;
            idle_pend_d = 1'b0;
            tail_d = 1'b0;
        end else begin
            if (rt_tick && left_q != 4'h0) begin
                trt_d = trt_q + 4'h1;
                if (trt_q == AST_RT_LAST) begin
                    sh_d = {1'b1, sh_q[12:1]}; // lsb first, sixteen ticks per bit
                    left_d = left_q - 4'h1;
                    tx_end = (left_q == 4'h1);
                end
            end
            if (tx_on && !te_prev_q) begin
                idle_pend_d = 1'b1; // enable edge queues preamble or idle
                tx_drop = (left_q == 4'h0) & ~txe_q; // re-enabled after the stop bit
            end
            if (tx_end) begin
                kind_d = AST_TXK_NONE;
                trt_d = 4'h0;
                case (1'b1)
                    !tx_on: begin
                        left_d = 4'h0; // finish current, then rest
                    end
                    send_break_bit: begin
                        kind_d = AST_TXK_BREAK;
                        sh_d = 13'h0000; // all-zero break, no framing bits
                        left_d = frm_len + {3'b000, long_brk};
                        tail_d = 1'b1;
                    end
                    tail_q: begin
                        kind_d = AST_TXK_TAIL;
                        sh_d = 13'h1FFF; // guard one after the last break
                        left_d = 4'h1;
                        tail_d = 1'b0;
                    end
                    idle_pend_q || (tx_on && !te_prev_q): begin
                        kind_d = AST_TXK_IDLE;
                        sh_d = 13'h1FFF; // idle character of ones
                        left_d = frm_len;
                        idle_pend_d = 1'b0;
                    end
                    !txe_q: begin
                        kind_d = AST_TXK_DATA;
                        sh_d = {3'b111, wlen9 ? ctl3_q[AST_B_TX8] : 1'b1, txbuf_q, 1'b0};
                        left_d = frm_len;
                        tx_take = 1'b1;
                    end
                    default: begin
                        left_d = 4'h0;
                    end
                endcase
            end
        end
        // line level: idle one when empty, flipped on request
        txd_d = ((left_d != 4'h0) ? sh_d[0] : 1'b1) ^ pol_flip;
        oe_d = iface_on & (tx_on | left_d != 4'h0);
    end

    // registers only
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            kind_q <= AST_TXK_NONE;
            sh_q <= 13'h1FFF;
            left_q <= 4'h0;
            trt_q <= 4'h0;
            idle_pend_q <= 1'b0;
            tail_q <= 1'b0;
            te_prev_q <= 1'b0;
            txd_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            kind_q <= kind_d;
            sh_q <= sh_d;
            left_q <= left_d;
            trt_q <= trt_d;
            idle_pend_q <= idle_pend_d;
            tail_q <= tail_d;
            te_prev_q <= te_prev_d;
            txd_q <= txd_d;
            oe_q <= oe_d;
        end
    end

    assign txd_out = txd_q;
    assign txd_oe_out = oe_q;
    assign rx_pin_claim_out = iface_on & rx_on;

    // receiver: start search, mid-bit sampling, break recognition
    always_comb begin
        rst_d = rst_q;
        rrt_d = rrt_q;
        ridx_d = ridx_q;
        rsh_d = rsh_q;
        allz_d = allz_q;
        rxl_d = (s2_q == s3_q) ? s3_q : rxl_q; // second and third stage must agree
        rxp_d = rxl_q;
        rx_done = 1'b0;
        rx_brk = 1'b0;
        rx_ferr = 1'b0;
        case (rst_q)
            AST_RX_IDLE: begin
                if (iface_on && rx_on && rxp_q && !rxl_q) begin
                    rst_d = AST_RX_RUN;
                    rrt_d = 4'h0;
                    ridx_d = 4'h0;
                    allz_d = 1'b1;
                end
            end
            AST_RX_RUN: begin
                if (!(iface_on && rx_on)) begin
                    rst_d = AST_RX_IDLE;
                end else if (rt_tick) begin
                    rrt_d = rrt_q + 4'h1;
                    if (rrt_q == AST_RT_SAMPLE) begin
                        allz_d = allz_q & ~rxl_q;
                        ridx_d = ridx_q + 4'h1;
                        if (ridx_q == 4'h0) begin
                            if (rxl_q) begin
                                rst_d = AST_RX_IDLE; // false start
                            end
                        end else if (ridx_q <= ndata) begin
                            rsh_d = {rxl_q, rsh_q[8:1]};
                        end else if (allz_q && !rxl_q && long_brk && ridx_q == ndata + 4'h1) begin
                            rst_d = AST_RX_RUN; // long mode needs one more zero
                        end else begin
                            rst_d = AST_RX_IDLE;
                            rx_done = 1'b1;
                            rx_brk = allz_q & ~rxl_q;
                            rx_ferr = ~rxl_q | (ridx_q != ndata + 4'h1);
                        end
                    end
                end
            end
            default: begin
                rst_d = AST_RX_IDLE;
            end
        endcase
    end

    // registers only; first synchroniser stage feeds the second alone
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_q <= AST_RX_IDLE;
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            rxl_q <= 1'b1;
            rxp_q <= 1'b1;
            rrt_q <= 4'h0;
            ridx_q <= 4'h0;
            rsh_q <= 9'h000;
            allz_q <= 1'b0;
        end else begin
            rst_q <= rst_d;
            s1_q <= rxd_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rxl_q <= rxl_d;
            rxp_q <= rxp_d;
            rrt_q <= rrt_d;
            ridx_q <= ridx_d;
            rsh_q <= rsh_d;
            allz_q <= allz_d;
        end
    end
endmodule : ast_serial_top

// file: tb/ast_serial_top_assertions.sv
// checker on the top ports: bus handshake, pin release, bit timing
// assumes a bind to ast_serial_top; BIT is the shortest bit time in clocks
`timescale 1ns/1ps
module ast_serial_top_assertions #(parameter int BIT = 16) (
    // watched ports
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic txd_out,
    input wire logic txd_oe_out,
    input wire logic rx_pin_claim_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    logic [15:0] run_q; // cycles at present level
    logic last_q; // level one cycle ago
    logic oe_q; // pin driven one cycle ago
    // saturates so a long idle cannot wrap into a false short run
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_q <= 16'h0000;
            last_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            run_q <= (txd_out != last_q || !txd_oe_out) ? 16'h0001 : run_q + 16'(run_q != 16'hFFFF);
            last_q <= txd_out;
            oe_q <= txd_oe_out;
        end
    end
    wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("wait too long");
    wait_first_a: assert property ($rose(avs_read_in) || $rose(avs_write_in) |-> avs_waitrequest_out)
        else $error("no wait");
    no_req_a: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
        else $error("stray wait");
    rd_upper_a: assert property (avs_readdata_out[31:8] == 24'h000000)
        else $error("upper bits");
    bit_len_a: assert property ((txd_out != last_q) && txd_oe_out && oe_q |-> run_q >= BIT)
        else $error("short bit");
    oe_cause_a: assert property ($changed(txd_oe_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
        else $error("oe moved");
    claim_cause_a: assert property ($changed(rx_pin_claim_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
        else $error("claim moved");
    off_idle_a: assert property (!txd_oe_out |-> txd_out)
        else $error("line not idle");
endmodule : ast_serial_top_assertions

// file: tb/ast_far_end.sv
// far end device: decodes frames on the transmit pin, sends breaks on rxd
// assumes 8 bits plus one sampled position; bit time given in bus clocks
`timescale 1ns/1ps
module ast_far_end (
    input wire logic clk_sys_in,
    input wire logic txd_in,
    input wire logic [7:0] bit_in,
    input wire logic brk_in,
    output logic rxd_out,
    output logic [8:0] got_out,
    output logic got_stb_out
);
    initial begin
        rxd_out = 1'b1;
        got_out = 9'h000;
        got_stb_out = 1'b0;
    end
    // sample mid-bit, lsb first; ninth slot is stop or bit 8
    always begin
        @(negedge txd_in);
        repeat (bit_in / 2) @(posedge clk_sys_in);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_in) @(posedge clk_sys_in);
            got_out[i] <= txd_in;
        end
        got_stb_out <= 1'b1;
        @(posedge clk_sys_in);
        got_stb_out <= 1'b0;
    end
    // eleven zero bits, more than a short break needs
    always @(posedge brk_in) begin
        @(posedge clk_sys_in);
        rxd_out <= 1'b0;
        repeat (11 * bit_in) @(posedge clk_sys_in);
        rxd_out <= 1'b1;
    end
endmodule : ast_far_end

// file: tb/tb_ast_serial_top.sv
// bench: registers, frames, breaks, polarity, clock choice, pin release
// assumes a 40 MHz bus clock and the far end model on the pins
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_ast_serial_top;
    import ast_pkg::*;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic src = 1'b0, rd = 1'b0, wr = 1'b0, brk = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] bt = 8'h10;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wq, txd, oe, claim, irq, rxd, stb;
    logic [8:0] got;
    int failures = 0, n_compared = 0, cyc = 0;
    initial forever #12.5 clk_sys_in = ~clk_sys_in;
    ast_serial_top ast_serial_top_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_src_choice_in(src),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .rxd_in(rxd),
        .txd_out(txd), .txd_oe_out(oe), .rx_pin_claim_out(claim), .tx_irq_out(irq));
    ast_far_end ast_far_end_inst (.clk_sys_in(clk_sys_in), .txd_in(txd), .bit_in(bt), .brk_in(brk),
        .rxd_out(rxd), .got_out(got), .got_stb_out(stb));
    // hold until waitrequest is low at a rising edge
    task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] v);
        @(posedge clk_sys_in);
        addr <= {i, 2'b00};
        wd <= 32'(v);
        wr <= w;
        rd <= !w;
        do @(posedge clk_sys_in); while (wq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        if (!w) `CHK(rdat[7:0], v)
        @(negedge clk_sys_in); // writes settled
    endtask : bus
    task automatic frame(input logic [8:0] e);
        do @(negedge clk_sys_in); while (stb !== 1'b1);
        `CHK(got, e)
    endtask : frame
    task automatic t_regs();
        bus(1'b0, AST_IDX_STA1, AST_RST_STA1);
        bus(1'b0, AST_IDX_CTL2, AST_RST_CTL);
        bus(1'b1, AST_IDX_BAUD, 8'hFF);
        bus(1'b0, AST_IDX_BAUD, AST_BAUD_WMASK);
        bus(1'b1, AST_IDX_BAUD, 8'h00);
        bus(1'b1, 6'h01, 8'hFF);
        bus(1'b0, 6'h01, 8'h00);
    endtask : t_regs
    task automatic t_tx();
        bus(1'b1, AST_IDX_CTL1, 8'h40);
        bus(1'b1, AST_IDX_CTL2, 8'h0C);
        `CHK(claim, 1'b1)
        bus(1'b0, AST_IDX_STA1, 8'h80);
        bus(1'b1, AST_IDX_DATA, 8'hA5);
        bus(1'b0, AST_IDX_STA1, 8'h00);
        frame(9'h1A5);
        repeat (20) @(posedge clk_sys_in);
        bus(1'b0, AST_IDX_STA1, 8'hC0);
        bus(1'b1, AST_IDX_CTL2, 8'hCC);
        `CHK(irq, 1'b1)
    endtask : t_tx
    task automatic t_nine();
        bus(1'b1, AST_IDX_CTL1, 8'h50);
        bus(1'b1, AST_IDX_CTL3, 8'h00);
        bus(1'b1, AST_IDX_DATA, 8'h5A);
        frame(9'h05A);
        bus(1'b1, AST_IDX_CTL1, 8'h40);
    endtask : t_nine
    task automatic t_brk();
        bus(1'b1, AST_IDX_CTL2, 8'h0D);
        frame(9'h000);
        repeat (200) @(posedge clk_sys_in);
        bus(1'b0, AST_IDX_STA1, 8'h80);
        bus(1'b1, AST_IDX_DATA, 8'h3C);
        bus(1'b1, AST_IDX_CTL2, 8'h0C);
        frame(9'h13C);
    endtask : t_brk
    task automatic t_rxbrk();
        brk <= 1'b1;
        repeat (230) @(posedge clk_sys_in);
        bus(1'b0, AST_IDX_STA1, 8'hE2);
        bus(1'b0, AST_IDX_STA2, 8'h02);
        bus(1'b0, AST_IDX_CTL3, 8'h00);
        bus(1'b0, AST_IDX_DATA, 8'h00);
        bus(1'b0, AST_IDX_STA2, 8'h00);
    endtask : t_rxbrk
    task automatic t_pol();
        bus(1'b1, AST_IDX_CTL1, 8'h60);
        repeat (40) @(posedge clk_sys_in);
        `CHK(txd, 1'b0)
        bus(1'b1, AST_IDX_CTL1, 8'h40);
        repeat (200) @(posedge clk_sys_in);
    endtask : t_pol
    task automatic t_clk();
        src <= 1'b1;
        bt <= 8'h40;
        bus(1'b0, AST_IDX_STA1, 8'hC0);
        bus(1'b1, AST_IDX_DATA, 8'hC3);
        frame(9'h1C3);
        bus(1'b1, AST_IDX_CTL1, 8'h00);
        @(negedge clk_sys_in);
        `CHK({oe, claim}, 2'b00)
    endtask : t_clk
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        t_regs();
        t_tx();
        t_nine();
        t_brk();
        t_rxbrk();
        t_pol();
        t_clk();
        end_of_test();
    end
endmodule : tb_ast_serial_top
bind ast_serial_top ast_serial_top_assertions #(.BIT(16)) ast_serial_top_assertions_inst (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .txd_out(txd_out),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .txd_oe_out(txd_oe_out),
    .rx_pin_claim_out(rx_pin_claim_out));
